// ==== rtcu_core.sv ====
// regulatory test command unit: decodes test commands written over avalon-mm,
// keeps channel, power and mapping settings and walks the test state.
// assumes a 10 MHz clock, synchronous reset and a master that holds requests
// until waitrequest is low.
//
// How it works
// - enable command: 1 enables, 0 disables; off; code ignores 0 unless test inactive
// - association status reads 0x31 while enabled
// - stop ends running test, leaves mode
// - normal cellular functions blocked until stopped
// - transmit start uses stored channel, power
// - transmit stop ends the modulated transmit
// - set channel stores 0 to 65535
// - channel readback returns last stored value
// - power is 12-bit signed sixteenths dBm
// - only whole dBm part drives radio
// - power readback returns last stored value
// - receive start uses stored channel
// - mapping accepts 0, 1, 4; defaults 4
// - mapping readback returns current setting
// - state codes 0 to 5 as listed
// - receive entry up to two minutes, error shown
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module rtcu_core
#(
  parameter longint RX_WAIT = rtcu_pkg::RX_WAIT_CYC  // receive entry wait, cycles
)
(
  input  wire logic        ref_clk,           // system clock
  input  wire logic        rst,               // synchronous reset
  input  wire logic [3:0]  avs_address,       // byte address
  input  wire logic        avs_read,          // read request
  input  wire logic        avs_write,         // write request
  input  wire logic [31:0] avs_writedata,     // write data
  input  wire logic [3:0]  avs_byteenable,    // byte lanes
  output logic [31:0]      avs_readdata,      // read data
  output logic             avs_waitrequest,   // stall
  output logic             tx_active,         // modulated transmit on
  output logic             rx_active,         // receive test on
  output logic [15:0]      radio_channel,     // channel in use
  output logic [2:0]       radio_mapping,     // channel numbering scheme
  output logic [7:0]       radio_power_dbm,   // whole dBm, signed
  output logic             cellular_blocked   // normal functions held off
);
  import rtcu_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_INACTIVE, S_TRANS, S_IDLE, S_RX_WAIT, S_RX, S_TX, S_STOPPING
  } fsm_t;

  fsm_t        state, next_state;        // test state machine
  logic        enabled, next_enabled;    // test mode enable
  logic [15:0] chan, next_chan;          // stored channel
  logic [11:0] pwr, next_pwr;            // stored power, sixteenths dBm
  logic [2:0]  map, next_map;            // stored mapping
  logic        bad_map, next_bad_map;    // sticky: illegal mapping refused
  logic        ack, next_ack;            // one-cycle answer phase
  logic [31:0] rdata, next_rdata;        // registered read data
  logic        tmr_load;                 // start a settle wait
  logic [TIMER_W-1:0] tmr_count;         // length of that wait
  logic        tmr_cancel;               // abandon a wait
  logic        tmr_done;                 // wait expired
  logic        wr_cmd;                   // command write taken this cycle
  logic [CMD_CODE_W-1:0] code;           // command code field
  logic [ARG_W-1:0]      arg;            // argument field
  logic [2:0]  state_code;               // reported test state

  assign code   = avs_writedata[CMD_CODE_LSB +: CMD_CODE_W];
  assign arg    = avs_writedata[ARG_W-1:0];
  // commands take effect on the accepting edge, when waitrequest is low
  assign wr_cmd = avs_write && ack && avs_address == OFS_CMD && (&avs_byteenable[2:0]);

  // ----------------------------------------------------------------
  // settle timer
  // ----------------------------------------------------------------
  rtcu_timer u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (tmr_load),
    .count   (tmr_count),
    .cancel  (tmr_cancel),
    .done    (tmr_done)
  );

  // ----------------------------------------------------------------
  // state reporting
  // ----------------------------------------------------------------
  // receive entry shows error while the radio reconfigures
  always_comb
  begin
    unique case (state)
      S_INACTIVE: state_code = ST_INACTIVE;
      S_TRANS:    state_code = ST_TRANS;
      S_STOPPING: state_code = ST_TRANS;
      S_IDLE:     state_code = ST_IDLE;
      S_RX_WAIT:  state_code = ST_ERROR;
      S_RX:       state_code = ST_RX;
      S_TX:       state_code = ST_TX;
      default:    state_code = ST_ERROR;          // unused code reads as error
    endcase
  end

  // ----------------------------------------------------------------
  // command decode and test state machine
  // ----------------------------------------------------------------
  // commands are ignored while test mode is disabled; enable is needed first
  always_comb
  begin
    next_state   = state;
    next_enabled = enabled;
    next_chan    = chan;
    next_pwr     = pwr;
    next_map     = map;
    next_bad_map = bad_map;
    tmr_load     = 1'b0;
    tmr_count    = TIMER_W'(TRANS_CYC);
    tmr_cancel   = 1'b0;
    if (wr_cmd)
    begin
      unique case (code)
        CMD_ENABLE:
          if (arg == 16'h0001)
            next_enabled = 1'b1;
          else if (arg == 16'h0000 && state == S_INACTIVE)
            next_enabled = 1'b0;
        CMD_START:
          if (enabled && state == S_INACTIVE)
          begin
            next_state = S_TRANS;
            tmr_load   = 1'b1;
          end
        CMD_STOP:
          if (state != S_INACTIVE)
          begin
            next_state = S_STOPPING;
            tmr_load   = 1'b1;
          end
        CMD_TX_START:
          if (state == S_IDLE)
            next_state = S_TX;
        CMD_TX_STOP:
          if (state == S_TX)
            next_state = S_IDLE;
        CMD_RX_START:
          if (state == S_IDLE)
          begin
            next_state = S_RX_WAIT;
            tmr_load   = 1'b1;
            tmr_count  = TIMER_W'(RX_WAIT);
          end
        CMD_SET_CHAN:
          if (enabled)
            next_chan = arg;
        CMD_SET_PWR:
          if (enabled)
            next_pwr = arg[PWR_W-1:0];
        CMD_SET_MAP:
          if (enabled)
          begin
            if (arg[2:0] inside {MAP_ARFCN, MAP_ARFCN_PCS, MAP_EARFCN}
                && arg[ARG_W-1:3] == '0)
              next_map = arg[2:0];
            else
              next_bad_map = 1'b1;                // illegal value refused
          end
        default: ;                                // unknown codes ignored
      endcase
    end
    // timer expiries finish the transitional states
    if (tmr_done && !tmr_load)
    begin
      unique case (state)
        S_TRANS:    next_state = S_IDLE;
        S_RX_WAIT:  next_state = S_RX;
        S_STOPPING: next_state = S_INACTIVE;
        default:    ;
      endcase
    end
  end

  // registers only
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state   <= S_INACTIVE;
      enabled <= 1'b0;
      chan    <= CHAN_RESET;
      pwr     <= PWR_RESET;
      map     <= MAP_EARFCN;
      bad_map <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      enabled <= next_enabled;
      chan    <= next_chan;
      pwr     <= next_pwr;
      map     <= next_map;
      bad_map <= next_bad_map;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave: one wait state, then the answer
  // ----------------------------------------------------------------
  // read data is captured in the stall cycle so it stands at the accepting edge;
  // the sticky mapping error flag is not touched here, only reset clears it
  always_comb
  begin
    next_ack   = (avs_read || avs_write) && !ack;
    next_rdata = rdata;
    if ((avs_read && !ack))
    begin
      unique case (avs_address)
        OFS_STATE:   next_rdata = {13'h0000, enabled, 2'b00,
                                   enabled ? ASSOC_TEST : ASSOC_NORMAL,
                                   5'h00, state_code};
        OFS_CHANNEL: next_rdata = {16'h0000, chan};
        OFS_POWER:   next_rdata = {12'h000, bad_map, map,
                                   4'h0, pwr};
        default:     next_rdata = 32'h0000_0000;
      endcase
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign avs_readdata    = rdata;

  // registers only
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ack   <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      ack   <= next_ack;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // radio control outputs
  // ----------------------------------------------------------------
  logic next_tx, next_rx, next_blk;
  logic [7:0] next_dbm;

  always_comb
  begin
    next_tx  = next_state == S_TX;
    next_rx  = next_state == S_RX;
    next_blk = next_state != S_INACTIVE;
    // dropping the four fraction bits keeps the sign; negative fractions round down
    next_dbm = next_pwr[PWR_W-1:PWR_FRAC];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tx_active        <= 1'b0;
      rx_active        <= 1'b0;
      cellular_blocked <= 1'b0;
      radio_power_dbm  <= 8'h00;
      radio_channel    <= CHAN_RESET;
      radio_mapping    <= MAP_EARFCN;
    end
    else
    begin
      tx_active        <= next_tx;
      rx_active        <= next_rx;
      cellular_blocked <= next_blk;
      radio_power_dbm  <= next_dbm;
      radio_channel    <= next_chan;
      radio_mapping    <= next_map;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  enable_default_a: assert property (@(posedge ref_clk)
    $fell(rst) |-> !enabled && map == MAP_EARFCN)
    else $error("enable or mapping wrong after reset");
  assoc_value_a: assert property (@(posedge ref_clk) disable iff (rst)
    enabled && avs_read && !ack && avs_address == OFS_STATE
    |=> avs_readdata[15:8] == ASSOC_TEST)
    else $error("association status not 0x31 in test mode");
  stop_ends_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_cmd && code == CMD_STOP && state != S_INACTIVE
    |=> state == S_STOPPING ##1 !tx_active && !rx_active)
    else $error("stop did not end the test");
  // the blocked output is registered from the next state, so it matches state now
  blocked_held_a: assert property (@(posedge ref_clk) disable iff (rst)
    state != S_INACTIVE |-> cellular_blocked)
    else $error("cellular functions not blocked");
  tx_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_cmd && code == CMD_TX_START && state == S_IDLE
    |=> ##1 tx_active && radio_channel == $past(chan, 2))
    else $error("transmit did not start");
  tx_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_cmd && code == CMD_TX_STOP && state == S_TX
    |=> state == S_IDLE ##1 !tx_active)
    else $error("transmit did not stop");
  chan_store_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_cmd && code == CMD_SET_CHAN && enabled |=> chan == $past(arg))
    else $error("channel not stored");
  power_whole_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_cmd && code == CMD_SET_PWR && enabled
    |=> radio_power_dbm == $past(arg[PWR_W-1:PWR_FRAC]))
    else $error("power fraction not discarded");
  map_legal_a: assert property (@(posedge ref_clk) disable iff (rst)
    map == MAP_ARFCN || map == MAP_ARFCN_PCS || map == MAP_EARFCN)
    else $error("illegal channel mapping held");
  // the settle timer needs one cycle to load and one to report its expiry
  start_walk_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_cmd && code == CMD_START && enabled && state == S_INACTIVE
    |=> state == S_TRANS ##1 state == S_TRANS ##[1:1000] state == S_IDLE)
    else $error("start did not reach idle");

endmodule
`default_nettype wire

// ==== rtcu_host.sv ====
// host model: avalon-mm master that writes test commands and polls the test state
// assumes a slave that stalls with waitrequest; only the bench watchdog ends a wait
`timescale 1ns/1ns
`default_nettype none
module rtcu_host
(
  input  wire logic        ref_clk,          // system clock
  input  wire logic        rst,              // synchronous reset
  output logic [3:0]       avs_address,      // byte address
  output logic             avs_read,         // read request
  output logic             avs_write,        // write request
  output logic [31:0]      avs_writedata,    // write data
  output logic [3:0]       avs_byteenable,   // byte lanes, always all set
  input  wire logic [31:0] avs_readdata,     // read data
  input  wire logic        avs_waitrequest   // stall
);
  import rtcu_pkg::*;
  // ----------------------------------------------------------------
  // idle bus
  // ----------------------------------------------------------------
  initial
  begin
    avs_address    = 4'hF;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'hA5A5A5A5;
    avs_byteenable = 4'hF;
  end

  // one transfer: raised just after an edge and held until waitrequest is
  // sampled low at a rising edge; read data is taken at that same edge, and
  // the release is non-blocking so the slave still sees the request there
  task automatic xfer(input logic rd_n_wr, input logic [3:0] adr, input logic [31:0] wd,
                      output logic [31:0] rdat);
    @(posedge ref_clk);
    avs_address   <= adr;
    avs_read      <= rd_n_wr;
    avs_write     <= !rd_n_wr;
    avs_writedata <= wd;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge ref_clk);
    rdat = avs_readdata;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    // released lines show inverted junk, not the last value
    avs_address   <= ~adr;
    avs_writedata <= ~wd;
  endtask

  task automatic rd(input logic [3:0] adr, output logic [31:0] d);
    xfer(1'b1, adr, 32'h0, d);
  endtask

  task automatic cmd(input cmd_t code, input logic [15:0] arg);
    logic [31:0] d;
    xfer(1'b0, OFS_CMD, {12'h0, code, arg}, d);
  endtask

  // keeps polling until the wanted mode shows, bounded by a poll count
  task automatic poll(input logic [2:0] want, input int limit, output logic [2:0] got);
    logic [31:0] d;
    int          n;
    n = 0;
    do
    begin
      rd(OFS_STATE, d);
      n++;
    end
    while (d[2:0] !== want && n < limit);
    got = d[2:0];
  endtask
endmodule
`default_nettype wire

// ==== rtcu_pkg.sv ====
// package for the regulatory test command unit: register map, encodings, timing
// assumes a 10 MHz system clock and an avalon-mm slave port with 32-bit data
package rtcu_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CMD     = 4'h0;  // command code and argument, write
  localparam logic [3:0] OFS_STATE   = 4'h4;  // test state and association status
  localparam logic [3:0] OFS_CHANNEL = 4'h8;  // stored channel number
  localparam logic [3:0] OFS_POWER   = 4'hC;  // stored power, mapping, flags

  // ----------------------------------------------------------------
  // command register layout
  // ----------------------------------------------------------------
  localparam int CMD_CODE_LSB = 16;  // command code in bits 19:16
  localparam int CMD_CODE_W   = 4;
  localparam int ARG_W        = 16;  // argument in bits 15:0

  typedef enum logic [3:0] {
    CMD_ENABLE   = 4'h0,  // argument 0 disables only while test inactive, 1 enables
    CMD_START    = 4'h1,
    CMD_STOP     = 4'h2,
    CMD_TX_START = 4'h5,
    CMD_TX_STOP  = 4'h6,
    CMD_SET_CHAN = 4'h7,
    CMD_SET_PWR  = 4'h9,
    CMD_RX_START = 4'hD,
    CMD_SET_MAP  = 4'hE
  } cmd_t;

  // ----------------------------------------------------------------
  // reported test state values
  // ----------------------------------------------------------------
  localparam logic [2:0] ST_INACTIVE = 3'h0;
  localparam logic [2:0] ST_TRANS    = 3'h1;
  localparam logic [2:0] ST_IDLE     = 3'h2;
  localparam logic [2:0] ST_RX       = 3'h3;
  localparam logic [2:0] ST_TX       = 3'h4;
  localparam logic [2:0] ST_ERROR    = 3'h5;

  // ----------------------------------------------------------------
  // status, mapping and power constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  ASSOC_TEST    = 8'h31;  // reported while test mode enabled
  localparam logic [7:0]  ASSOC_NORMAL  = 8'hFF;  // reported otherwise
  localparam logic [2:0]  MAP_ARFCN     = 3'h0;
  localparam logic [2:0]  MAP_ARFCN_PCS = 3'h1;
  localparam logic [2:0]  MAP_EARFCN    = 3'h4;
  localparam int          PWR_W         = 12;
  localparam int          PWR_FRAC      = 4;
  localparam logic [11:0] PWR_RESET     = 12'h000;
  localparam logic [15:0] CHAN_RESET    = 16'h0000;

  // ----------------------------------------------------------------
  // timing: radio settle times
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 10_000_000;
  localparam int TRANS_US    = 100;  // start and stop settle time
  localparam int TRANS_CYC   = (TRANS_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                               TRANS_US * (CLK_HZ / 1_000_000);
  localparam int RX_WAIT_S   = 120;  // receive entry takes up to two minutes
  localparam longint RX_WAIT_CYC = longint'(RX_WAIT_S) * longint'(CLK_HZ);
  localparam int TIMER_W     = 32;

endpackage

// ==== rtcu_timer.sv ====
// settle timer: loads a count and pulses done when it has run down
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module rtcu_timer
(
  input  wire logic                         ref_clk,  // system clock
  input  wire logic                         rst,      // synchronous reset
  input  wire logic                         load,     // one-cycle load pulse
  input  wire logic [rtcu_pkg::TIMER_W-1:0] count,    // cycles to wait, at least one
  input  wire logic                         cancel,   // abandons a running wait
  output logic                              done      // one-cycle pulse at expiry
);
  import rtcu_pkg::*;

  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  logic [TIMER_W-1:0] remain;       // cycles left
  logic               run;          // wait in progress
  logic [TIMER_W-1:0] next_remain;
  logic               next_run;
  logic               next_done;

  // next values: load wins over cancel so a new wait is never dropped
  always_comb
  begin
    next_remain = remain;
    next_run    = run;
    next_done   = 1'b0;
    if (load)
    begin
      next_remain = count;
      next_run    = 1'b1;
    end
    else if (cancel)
      next_run = 1'b0;
    else if (run)
    begin
      if (remain <= TIMER_W'(1))
      begin
        next_run  = 1'b0;
        next_done = 1'b1;
      end
      else
        next_remain = remain - TIMER_W'(1);
    end
  end

  // registers only
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      remain <= '0;
      run    <= 1'b0;
      done   <= 1'b0;
    end
    else
    begin
      remain <= next_remain;
      run    <= next_run;
      done   <= next_done;
    end
  end

endmodule
`default_nettype wire

// ==== tb_radio_regulatory_test_command_unit.sv ====
// testbench for the regulatory test command unit: command sequences with expected values
// assumes the host model drives the avalon-mm port; receive wait shortened to 50 cycles
`timescale 1ns/1ns
`default_nettype none
module tb_radio_regulatory_test_command_unit;
  import rtcu_pkg::*;
  logic        ref_clk = 1'b0;    // 100 ns clock
  logic        rst     = 1'b1;    // synchronous reset
  logic [3:0]  avs_address;       // host bus
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        tx_active;         // radio side
  logic        rx_active;
  logic [15:0] radio_channel;
  logic [2:0]  radio_mapping;
  logic [7:0]  radio_power_dbm;
  logic        cellular_blocked;
  int          err_count = 0;     // mismatches
  int          cmp_count = 0;     // comparisons
  logic [31:0] d;                 // read word
  logic [2:0]  s;                 // polled state
  logic [11:0] pw [3] = '{12'hFF0, 12'h188, 12'hD80};  // -1, 24.5, -40 dBm
  logic [2:0]  mp [3] = '{MAP_ARFCN, MAP_ARFCN_PCS, MAP_EARFCN};

  always #50 ref_clk = ~ref_clk;

  rtcu_host u_host (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  rtcu_core #(.RX_WAIT(50)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_active(tx_active), .rx_active(rx_active), .radio_channel(radio_channel),
    .radio_mapping(radio_mapping), .radio_power_dbm(radio_power_dbm),
    .cellular_blocked(cellular_blocked));

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // registered outputs are read mid-cycle, away from the launching edge
  task automatic settle;
    @(negedge ref_clk);
  endtask

  task automatic chk_state(input logic [2:0] st, input logic [7:0] asc, input logic en);
    u_host.rd(OFS_STATE, d);
    chk(d & 32'h0004FF07, {13'h0, en, 2'h0, asc, 5'h0, st});
  endtask

  task automatic chk_pwr(input logic [11:0] p, input logic [2:0] m, input logic bad);
    u_host.rd(OFS_POWER, d);
    chk(d & 32'h000F0FFF, {12'h0, bad, m, 4'h0, p});
  endtask

  task automatic chk_chan(input logic [15:0] ch);
    u_host.rd(OFS_CHANNEL, d);
    chk(d & 32'h0000FFFF, {16'h0, ch});
    settle;
    chk(32'(radio_channel), 32'(ch));
  endtask

  // watchdog: a full run takes a few thousand cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    finish_test;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    chk_state(ST_INACTIVE, ASSOC_NORMAL, 1'b0);
    chk_pwr(PWR_RESET, MAP_EARFCN, 1'b0);
    chk(32'({tx_active, rx_active, cellular_blocked}), 32'h0);
    u_host.rd(4'h2, d);
    chk(d, 32'h0);
    // test commands are refused while test mode is off
    u_host.cmd(CMD_START, 16'h0);
    u_host.cmd(CMD_SET_CHAN, 16'h1234);
    chk_state(ST_INACTIVE, ASSOC_NORMAL, 1'b0);
    chk_chan(CHAN_RESET);
    // defaults come from the reset just done
    u_host.cmd(CMD_ENABLE, 16'h1);
    chk_state(ST_INACTIVE, ASSOC_TEST, 1'b1);
    u_host.cmd(CMD_START, 16'h0);
    chk_state(ST_TRANS, ASSOC_TEST, 1'b1);
    settle;
    chk(32'(cellular_blocked), 32'h1);
    u_host.poll(ST_IDLE, 600, s);
    chk(32'(s), 32'(ST_IDLE));
    // channel boundaries
    u_host.cmd(CMD_SET_CHAN, 16'hFFFF);
    chk_chan(16'hFFFF);
    u_host.cmd(CMD_SET_CHAN, 16'h0000);
    chk_chan(16'h0000);
    // power: negative, fractional and a low -40 dBm value
    for (int i = 0; i < 3; i++)
    begin
      u_host.cmd(CMD_SET_PWR, {4'h0, pw[i]});
      chk_pwr(pw[i], MAP_EARFCN, 1'b0);
      settle;
      chk(32'(radio_power_dbm), 32'(pw[i][11:4]));
    end
    // every legal mapping, then an illegal one that must not stick
    for (int i = 0; i < 3; i++)
    begin
      u_host.cmd(CMD_SET_MAP, {13'h0, mp[i]});
      chk_pwr(pw[2], mp[i], 1'b0);
      settle;
      chk(32'(radio_mapping), 32'(mp[i]));
    end
    u_host.cmd(CMD_SET_MAP, 16'h0002);
    chk_pwr(pw[2], MAP_EARFCN, 1'b1);
    // transmit on an uplink channel
    u_host.cmd(CMD_SET_CHAN, 16'h13F6);
    u_host.cmd(CMD_TX_START, 16'h0);
    chk_state(ST_TX, ASSOC_TEST, 1'b1);
    settle;
    chk(32'({tx_active, radio_channel}), 32'h113F6);
    u_host.cmd(CMD_RX_START, 16'h0);
    chk_state(ST_TX, ASSOC_TEST, 1'b1);
    u_host.cmd(CMD_TX_STOP, 16'h0);
    chk_state(ST_IDLE, ASSOC_TEST, 1'b1);
    settle;
    chk(32'(tx_active), 32'h0);
    // receive entry shows the error state while it settles
    u_host.cmd(CMD_RX_START, 16'h0);
    chk_state(ST_ERROR, ASSOC_TEST, 1'b1);
    u_host.poll(ST_RX, 100, s);
    chk(32'(s), 32'(ST_RX));
    settle;
    chk(32'({rx_active, radio_channel}), 32'h113F6);
    u_host.cmd(CMD_ENABLE, 16'h0);
    chk_state(ST_RX, ASSOC_TEST, 1'b1);
    // stop in mid-receive
    u_host.cmd(CMD_STOP, 16'h0);
    chk_state(ST_TRANS, ASSOC_TEST, 1'b1);
    settle;
    chk(32'({rx_active, cellular_blocked}), 32'h1);
    u_host.poll(ST_INACTIVE, 600, s);
    chk(32'(s), 32'(ST_INACTIVE));
    settle;
    chk(32'(cellular_blocked), 32'h0);
    u_host.cmd(CMD_ENABLE, 16'h0);
    chk_state(ST_INACTIVE, ASSOC_NORMAL, 1'b0);
    // a second reset in mid-run restores defaults and clears the sticky flag
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    chk_pwr(PWR_RESET, MAP_EARFCN, 1'b0);
    chk_state(ST_INACTIVE, ASSOC_NORMAL, 1'b0);
    finish_test;
  end
endmodule
`default_nettype wire
